// ### dcache_maint_map.svh
// constants for the data-cache maintenance unit
`ifndef DCACHE_MAINT_MAP_SVH
`define DCACHE_MAINT_MAP_SVH

// ==========================================================================
// geometry defaults
`define DCM_BLOCK_BYTES   64
`define DCM_SETS          64
`define DCM_WAYS          8

// ==========================================================================
// address field layout
`define DCM_WORD_LSB      2
`define DCM_MOD_W         7
`define DCM_MOD_SHIFT     2
`define DCM_GUARD_BIT     0

// ==========================================================================
// reset values
`define DCM_VALID_RST     1'b0
`define DCM_DIRTY_RST     1'b0
`define DCM_LOCK_RST      1'b0
`define DCM_LRU_RST       8'h00
`define DCM_NC_RST        32'h0000_0000

`endif

// ### dcache_maint_pkg.sv
// types for the data-cache maintenance unit
package dcache_maint_pkg;

  // ========================================================================
  // operation kinds and controller states
  typedef enum logic {
    OP_COPYBACK   = 1'b0,
    OP_INVALIDATE = 1'b1
  } op_kind_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_DRAIN  = 4'b0010,
    ST_WBACK  = 4'b0100,
    ST_UPDATE = 4'b1000
  } maint_state_t;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic        valid;
    op_kind_t    kind;
    logic [31:0] guard;
    logic [31:0] base_operand;
    logic [6:0]  modifier;
  } maint_op_t;

  typedef struct packed {
    logic        en;
    logic [7:0]  way;
    logic [31:0] addr;
    logic [31:0] data;
    logic        mark_dirty;
    logic        lock;
  } line_upd_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic       hit;
    logic       dirty;
    logic       lock;
    logic [7:0] lru;
  } probe_t;

endpackage

// ### dcache_maint.sv
// data-cache tag, state and data arrays with copyback and invalidate operations
//
// Functional notes
// [RULE1] valid dirty copyback writes block, clears dirty
// [RULE2] target byte is base plus signed modifier; the code adds the sign-extended modifier times 4
// [RULE3] copied-back block stays resident and valid
// [RULE4] stall until the write-back finishes
// [RULE5] clean or absent copyback: nothing, no stall
// [RULE6] non-cacheable copyback touches no block
// [RULE7] copyback leaves replacement order alone
// [RULE8] copyback cancels prefetches, drains copyback buffers
// [RULE9] operations run only when guard bit 0 set
// [RULE10] false guard: no state change, no stall
// [RULE11] invalidate clears valid and dirty bits
// [RULE12] invalidated block is never written back
// [RULE13] invalidate stalls as needed; absent block: nothing
// [RULE14] non-cacheable invalidate touches no block
// [RULE15] invalidate clears valid even on locked blocks
// [RULE16] invalidate leaves replacement order alone
// [RULE17] invalidate cancels prefetches, drains copyback buffers
// [RULE18] drain and cancel before block state changes
`timescale 1ns/1ps
`default_nettype none
`include "dcache_maint_map.svh"

module dcache_maint #(
  parameter int BLOCK_BYTES = `DCM_BLOCK_BYTES,
  parameter int SETS        = `DCM_SETS,
  parameter int WAYS        = `DCM_WAYS
) (
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  input  wire dcache_maint_pkg::maint_op_t op_i,
  output logic                            stall_o,
  input  wire dcache_maint_pkg::line_upd_t upd_i,
  input  wire logic [31:0]                nc_base_i,
  input  wire logic [31:0]                nc_limit_i,
  output logic                            pf_cancel_o,
  output logic                            drain_req_o,
  input  wire logic                       cb_empty_i,
  output dcache_maint_pkg::mem_wr_t        mem_wr_o,
  input  wire logic                       mem_wr_ready_i,
  input  wire logic [31:0]                probe_addr_i,
  output dcache_maint_pkg::probe_t         probe_o
);

  // ========================================================================
  // geometry
  localparam int OFF_W  = $clog2(BLOCK_BYTES);
  localparam int SET_W  = (SETS > 1) ? $clog2(SETS) : 1;
  localparam int WAY_W  = (WAYS > 1) ? $clog2(WAYS) : 1;
  localparam int WORDS  = BLOCK_BYTES / 4;
  localparam int WRD_W  = (WORDS > 1) ? $clog2(WORDS) : 1;
  localparam int TAG_W  = 32 - OFF_W - SET_W;

  if (BLOCK_BYTES < 8 || (BLOCK_BYTES & (BLOCK_BYTES - 1)) != 0) begin : g_bad_block
    $error("BLOCK_BYTES must be a power of two of at least 8");
  end
  if (SETS < 2 || (SETS & (SETS - 1)) != 0) begin : g_bad_sets
    $error("SETS must be a power of two of at least 2");
  end
  if (WAYS < 1 || WAYS > 256) begin : g_bad_ways
    $error("WAYS must lie between 1 and 256");
  end

  typedef struct packed {
    logic             hit;
    logic [WAY_W-1:0] way;
  } look_t;

  // ========================================================================
  // arrays
  logic             valid_q [SETS][WAYS];
  logic             dirty_q [SETS][WAYS];
  logic             lock_q  [SETS][WAYS];
  logic [TAG_W-1:0] tag_q   [SETS][WAYS];
  logic [7:0]       lru_q   [SETS];
  logic [31:0]      data_q  [SETS][WAYS][WORDS];

  function automatic logic [SET_W-1:0] set_of(input logic [31:0] a);
    set_of = a[OFF_W +: SET_W];
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
    tag_of = a[31 -: TAG_W];
  endfunction

  function automatic look_t lookup(input logic [31:0] a);
    look_t r;
    r = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (valid_q[set_of(a)][w] && tag_q[set_of(a)][w] == tag_of(a)) begin
        r.hit = 1'b1;
        r.way = WAY_W'(w);
      end
    end
    lookup = r;
  endfunction

  // ========================================================================
  // operation decode
  dcache_maint_pkg::maint_state_t state_q, state_d;
  dcache_maint_pkg::op_kind_t     kind_q;
  logic [31:0]      line_addr_q;
  logic [SET_W-1:0] set_q;
  logic [WAY_W-1:0] way_q;
  logic [WRD_W-1:0] word_q;

  wire logic        idle      = (state_q == dcache_maint_pkg::ST_IDLE);
  wire logic [31:0] mod_ext   = 32'(signed'({op_i.modifier, 2'b00})); // [RULE2]
  wire logic [31:0] eff_addr  = op_i.base_operand + mod_ext; // [RULE2]
  wire logic        guard_ok  = op_i.guard[`DCM_GUARD_BIT]; // [RULE9]
  wire logic        in_nc     = (eff_addr >= nc_base_i) && (eff_addr < nc_limit_i);
  look_t            op_look;
  wire logic        op_dirty  = dirty_q[set_of(eff_addr)][op_look.way];
  wire logic        is_inval  = (op_i.kind == dcache_maint_pkg::OP_INVALIDATE);
  // [RULE5] [RULE6] [RULE10] [RULE13] [RULE14] only acting hits are accepted
  wire logic        accept    = idle && op_i.valid && guard_ok && !in_nc
                                && op_look.hit && (is_inval || op_dirty);
  wire logic        wb_kind   = (kind_q == dcache_maint_pkg::OP_COPYBACK);
  wire logic        wb_beat   = mem_wr_o.valid && mem_wr_ready_i;
  wire logic        wb_last   = wb_beat && (word_q == WRD_W'(WORDS - 1));
  wire logic [31:0] wb_addr   = line_addr_q | 32'({word_q, 2'b00});

  // lookup must follow the state arrays, not only the address
  always_comb begin
    op_look = lookup(eff_addr);
  end

  assign stall_o     = !idle; // [RULE4] [RULE13]
  assign drain_req_o = (state_q == dcache_maint_pkg::ST_DRAIN); // [RULE8] [RULE17]

  // ========================================================================
  // controller
  always_comb begin
    state_d = state_q;
    case (state_q)
      dcache_maint_pkg::ST_IDLE: begin
        if (accept)
          state_d = dcache_maint_pkg::ST_DRAIN; // [RULE18]
      end
      dcache_maint_pkg::ST_DRAIN: begin
        if (cb_empty_i)
          state_d = wb_kind ? dcache_maint_pkg::ST_WBACK
                            : dcache_maint_pkg::ST_UPDATE; // [RULE12]
      end
      dcache_maint_pkg::ST_WBACK: begin
        if (wb_last)
          state_d = dcache_maint_pkg::ST_UPDATE; // [RULE1]
      end
      dcache_maint_pkg::ST_UPDATE: begin
        state_d = dcache_maint_pkg::ST_IDLE;
      end
      default: begin
        state_d = dcache_maint_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q     <= dcache_maint_pkg::ST_IDLE;
      kind_q      <= dcache_maint_pkg::OP_COPYBACK;
      line_addr_q <= '0;
      set_q       <= '0;
      way_q       <= '0;
      pf_cancel_o <= 1'b0;
    end else begin
      state_q     <= state_d;
      pf_cancel_o <= accept; // [RULE8] [RULE17]
      if (accept) begin
        kind_q      <= op_i.kind;
        line_addr_q <= {eff_addr[31:OFF_W], OFF_W'(0)};
        set_q       <= set_of(eff_addr);
        way_q       <= op_look.way;
      end
    end
  end

  // ========================================================================
  // write-back of the block, one word per accepted beat
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_wr_o <= '0;
      word_q   <= '0;
    end else if (state_q == dcache_maint_pkg::ST_DRAIN && cb_empty_i && wb_kind) begin
      mem_wr_o <= '{valid: 1'b1, addr: line_addr_q, data: data_q[set_q][way_q][0]}; // [RULE1]
      word_q   <= '0;
    end else if (wb_last) begin
      mem_wr_o <= '0;
    end else if (wb_beat) begin
      mem_wr_o.addr <= wb_addr + 32'h0000_0004;
      mem_wr_o.data <= data_q[set_q][way_q][WRD_W'(word_q + 1'b1)];
      word_q        <= WRD_W'(word_q + 1'b1);
    end
  end

  // ========================================================================
  // line state; the maintenance path never writes the replacement state
  wire logic [SET_W-1:0] upd_set  = set_of(upd_i.addr);
  wire logic [WAY_W-1:0] upd_way  = upd_i.way[WAY_W-1:0];
  wire logic [WRD_W-1:0] upd_word = upd_i.addr[`DCM_WORD_LSB +: WRD_W];
  wire logic             maint_wr = (state_q == dcache_maint_pkg::ST_UPDATE);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int s = 0; s < SETS; s++) begin
        lru_q[s] <= `DCM_LRU_RST;
        for (int w = 0; w < WAYS; w++) begin
          valid_q[s][w] <= `DCM_VALID_RST;
          dirty_q[s][w] <= `DCM_DIRTY_RST;
          lock_q[s][w]  <= `DCM_LOCK_RST;
        end
      end
    end else begin
      if (maint_wr) begin
        dirty_q[set_q][way_q] <= 1'b0; // [RULE1] [RULE11]
        valid_q[set_q][way_q] <= wb_kind; // [RULE3] [RULE11] [RULE15]
      end
      if (upd_i.en) begin
        valid_q[upd_set][upd_way] <= 1'b1;
        lock_q[upd_set][upd_way]  <= upd_i.lock;
        lru_q[upd_set]            <= upd_i.way; // [RULE7] [RULE16]
        if (upd_i.mark_dirty)
          dirty_q[upd_set][upd_way] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (upd_i.en) begin
      tag_q[upd_set][upd_way]            <= tag_of(upd_i.addr);
      data_q[upd_set][upd_way][upd_word] <= upd_i.data;
    end
  end

  // ========================================================================
  // state probe
  look_t probe_look;

  always_comb begin
    probe_look = lookup(probe_addr_i);
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      probe_o <= '0;
    end else begin
      probe_o.hit   <= probe_look.hit;
      probe_o.dirty <= probe_look.hit && dirty_q[set_of(probe_addr_i)][probe_look.way];
      probe_o.lock  <= probe_look.hit && lock_q[set_of(probe_addr_i)][probe_look.way];
      probe_o.lru   <= lru_q[set_of(probe_addr_i)];
    end
  end

  // ========================================================================
  // checks
  wire logic line_valid = valid_q[set_q][way_q];
  wire logic line_dirty = dirty_q[set_q][way_q];
  wire logic [7:0] line_lru = lru_q[set_q];

  property p_guard_false;
    @(posedge clock_i) disable iff (!rst_b_i)
    idle && op_i.valid && !guard_ok |=> idle && !pf_cancel_o;
  endproperty
  a_guard_false: assert property (p_guard_false) // [RULE9] [RULE10]
    else $error("false guard caused a stall");

  property p_nc_quiet;
    @(posedge clock_i) disable iff (!rst_b_i)
    idle && op_i.valid && in_nc |=> idle;
  endproperty
  a_nc_quiet: assert property (p_nc_quiet) // [RULE6] [RULE14]
    else $error("non-cacheable operation was acted on");

  property p_miss_quiet;
    @(posedge clock_i) disable iff (!rst_b_i)
    idle && op_i.valid && (!op_look.hit || (!is_inval && !op_dirty)) |=> idle;
  endproperty
  a_miss_quiet: assert property (p_miss_quiet) // [RULE5] [RULE13]
    else $error("absent or clean target stalled");

  property p_accept_addr;
    @(posedge clock_i) disable iff (!rst_b_i)
    accept |=> pf_cancel_o && drain_req_o
      && line_addr_q[31:OFF_W] == $past(op_i.base_operand + mod_ext) >> OFF_W;
  endproperty
  a_accept_addr: assert property (p_accept_addr) // [RULE2] [RULE8] [RULE17]
    else $error("accepted operation mis-addressed or not drained");

  property p_drain_first;
    @(posedge clock_i) disable iff (!rst_b_i)
    drain_req_o && !cb_empty_i |=> drain_req_o && $stable(line_valid) && $stable(line_dirty);
  endproperty
  a_drain_first: assert property (p_drain_first) // [RULE18]
    else $error("line state changed before buffers drained");

  property p_no_inval_wb;
    @(posedge clock_i) disable iff (!rst_b_i)
    !wb_kind && !idle |-> !mem_wr_o.valid;
  endproperty
  a_no_inval_wb: assert property (p_no_inval_wb) // [RULE12]
    else $error("invalidated block written back");

  property p_wb_stall;
    @(posedge clock_i) disable iff (!rst_b_i)
    mem_wr_o.valid |-> stall_o && state_q == dcache_maint_pkg::ST_WBACK;
  endproperty
  a_wb_stall: assert property (p_wb_stall) // [RULE4]
    else $error("write-back without stall");

  property p_cb_result;
    @(posedge clock_i) disable iff (!rst_b_i)
    maint_wr && wb_kind && !upd_i.en |=> line_valid && !line_dirty && idle;
  endproperty
  a_cb_result: assert property (p_cb_result) // [RULE1] [RULE3]
    else $error("copyback left wrong line state");

  property p_inv_result;
    @(posedge clock_i) disable iff (!rst_b_i)
    maint_wr && !wb_kind && !upd_i.en |=> !line_valid && !line_dirty;
  endproperty
  a_inv_result: assert property (p_inv_result) // [RULE11] [RULE15]
    else $error("invalidate left line valid or dirty");

  property p_lru_kept;
    @(posedge clock_i) disable iff (!rst_b_i)
    !idle && !upd_i.en |=> $stable(line_lru);
  endproperty
  a_lru_kept: assert property (p_lru_kept) // [RULE7] [RULE16]
    else $error("replacement state changed by maintenance");

  c_copyback: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    wb_last ##1 maint_wr ##1 idle);
  c_invalidate: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    accept && is_inval ##1 drain_req_o ##[1:20] maint_wr);
  c_locked_inv: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    maint_wr && !wb_kind && lock_q[set_q][way_q]);
  c_guard_false: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    idle && op_i.valid && !guard_ok);

endmodule

`default_nettype wire

// ### dcm_mem_model.sv
// memory-side partner model: copyback buffer drain and write-beat acceptance
`timescale 1ns/1ps
`default_nettype none

module dcm_mem_model (
  input  wire logic                      clock_i,
  input  wire logic                      rst_b_i,
  input  wire dcache_maint_pkg::mem_wr_t mem_wr_i,
  input  wire logic                      drain_req_i,
  input  wire logic                      slow_i,
  input  wire logic                      pend_i,
  output logic                           ready_o,
  output logic                           cb_empty_o
);
  // ==========================================================================
  // buffer state and captured beats
  logic [63:0] beats [$];
  int          early;
  logic        pend_q;
  logic [1:0]  cnt_q;

  assign cb_empty_o = !pend_q;

  // ==========================================================================
  // drain a pending buffer a few cycles after the request
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
      cnt_q <= 2'h0;
      ready_o <= 1'b1;
    end else begin
      if (pend_i) begin
        pend_q <= 1'b1;
      end else if (drain_req_i && pend_q) begin
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == 2'h3) begin
          pend_q <= 1'b0;
        end
      end
      ready_o <= slow_i ? 1'($urandom % 2) : 1'b1;
      if (mem_wr_i.valid && ready_o) begin
        beats.push_back({mem_wr_i.addr, mem_wr_i.data});
      end
      if (mem_wr_i.valid && pend_q) begin
        early++;
      end
    end
  end
endmodule

`default_nettype wire

// ### dcache_maint_ops_tb.sv
// testbench for the data-cache copyback and invalidate operations
`timescale 1ns/1ps
`default_nettype none
`include "dcache_maint_map.svh"

module dcache_maint_ops_tb;
  localparam int WORDS = `DCM_BLOCK_BYTES / 4;
  localparam logic [31:0] BLK_A = 32'h0000_1040;
  localparam logic [31:0] BLK_B = 32'h0000_2080;
  localparam logic [31:0] BLK_C = 32'h0000_30C0;

  // ==========================================================================
  // signals and reference model
  logic                        clock_i;
  logic                        rst_b_i;
  dcache_maint_pkg::maint_op_t op_i;
  dcache_maint_pkg::line_upd_t upd_i;
  dcache_maint_pkg::mem_wr_t   mem_wr_o;
  dcache_maint_pkg::probe_t    probe_o;
  logic [31:0]                 nc_base_i;
  logic [31:0]                 nc_limit_i;
  logic [31:0]                 probe_addr_i;
  logic                        stall_o;
  logic                        pf_cancel_o;
  logic                        drain_req_o;
  logic                        cb_empty_i;
  logic                        mem_wr_ready_i;
  logic                        slow;
  logic                        pend;
  bit                          m_val [512];
  bit                          m_dirty [512];
  bit                          m_lock [512];
  logic [7:0]                  m_lru [64];
  logic [31:0]                 m_data [8192];
  int                          num_errors;
  int                          tests_run;

  dcache_maint dut (
    .clock_i       (clock_i),
    .rst_b_i       (rst_b_i),
    .op_i          (op_i),
    .stall_o       (stall_o),
    .upd_i         (upd_i),
    .nc_base_i     (nc_base_i),
    .nc_limit_i    (nc_limit_i),
    .pf_cancel_o   (pf_cancel_o),
    .drain_req_o   (drain_req_o),
    .cb_empty_i    (cb_empty_i),
    .mem_wr_o      (mem_wr_o),
    .mem_wr_ready_i(mem_wr_ready_i),
    .probe_addr_i  (probe_addr_i),
    .probe_o       (probe_o)
  );

  dcm_mem_model mem (
    .clock_i    (clock_i),
    .rst_b_i    (rst_b_i),
    .mem_wr_i   (mem_wr_o),
    .drain_req_i(drain_req_o),
    .slow_i     (slow),
    .pend_i     (pend),
    .ready_o    (mem_wr_ready_i),
    .cb_empty_o (cb_empty_i)
  );

  // ==========================================================================
  // compare, verdict, fill, probe and operation tasks
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic fill(input logic [31:0] a, input logic [7:0] w, input bit d, input bit l);
    logic [31:0] v;
    logic [31:0] wa;
    for (int i = 0; i < WORDS; i++) begin
      v = $urandom;
      wa = a + 32'(4 * i);
      @(posedge clock_i);
      upd_i <= '{en:1'b1, way:w, addr:wa, data:v, mark_dirty:d, lock:l};
      m_data[wa[14:2]] = v;
    end
    @(posedge clock_i);
    upd_i <= '0;
    m_val[a[14:6]] = 1'b1;
    m_dirty[a[14:6]] = d;
    m_lock[a[14:6]] = l;
    m_lru[a[11:6]] = w;
  endtask

  task automatic chk_probe(input logic [31:0] a);
    @(posedge clock_i);
    probe_addr_i <= a;
    @(posedge clock_i);
    #1;
    chk("probe_hit", m_val[a[14:6]], probe_o.hit);
    if (m_val[a[14:6]]) begin
      chk("probe_dirty", m_dirty[a[14:6]], probe_o.dirty);
      chk("probe_lock", m_lock[a[14:6]], probe_o.lock);
    end
    chk("probe_lru", m_lru[a[11:6]], probe_o.lru);
  endtask

  task automatic do_op(input dcache_maint_pkg::op_kind_t k, input logic [31:0] g,
                       input logic [31:0] b, input logic [6:0] m);
    logic [31:0] a;
    logic [31:0] e;
    bit          act;
    bit          cb;
    int          n;
    int          pf;
    n = 0;
    pf = 0;
    @(posedge clock_i);
    op_i <= '{valid:1'b1, kind:k, guard:g, base_operand:b, modifier:m};
    a = b + {{23{m[6]}}, m, 2'b00};
    cb = (k == dcache_maint_pkg::OP_COPYBACK);
    act = g[0] && !(a >= nc_base_i && a < nc_limit_i) && m_val[a[14:6]]
          && (!cb || m_dirty[a[14:6]]);
    @(posedge clock_i);
    #1;
    while (stall_o === 1'b1 && n < 500) begin
      if (pf_cancel_o === 1'b1) begin
        pf++;
      end
      n++;
      @(posedge clock_i);
      #1;
    end
    @(posedge clock_i);
    op_i <= '0;
    chk("stall_limit", 1, n < 500);
    chk("stalled", act, n > 0);
    chk("stall_span", 1, !act || n >= (cb ? WORDS + 2 : 2));
    chk("cancel_pulses", act, pf);
    chk("beat_count", (act && cb) ? WORDS : 0, mem.beats.size());
    for (int i = 0; i < mem.beats.size(); i++) begin
      e = {a[31:6], 6'h00} + 32'(4 * i);
      chk("beat", {e, m_data[e[14:2]]}, mem.beats[i]);
    end
    mem.beats.delete();
    if (act) begin
      m_dirty[a[14:6]] = 1'b0;
      m_val[a[14:6]] = cb;
    end
    chk_probe(a);
  endtask

  // ==========================================================================
  // clock, watchdog and scenarios
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  initial begin
    #400000;
    num_errors++;
    finish_test();
  end

  initial begin
    rst_b_i = 1'b0;
    op_i = '0;
    upd_i = '0;
    nc_base_i = 32'h0000_0000;
    nc_limit_i = 32'h0000_0000;
    probe_addr_i = 32'h0000_0000;
    slow = 1'b0;
    pend = 1'b0;
    num_errors = 0;
    tests_run = 0;
    for (int s = 0; s < 64; s++) begin
      m_lru[s] = `DCM_LRU_RST;
    end
    void'($urandom(95781));
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    #1;
    chk("reset_stall", 0, stall_o);
    chk("reset_probe", 0, probe_o);
    fill(BLK_A, 8'h01, 1'b1, 1'b0);
    fill(BLK_B, 8'h02, 1'b0, 1'b1);
    fill(BLK_C, 8'h04, 1'b1, 1'b0);
    do_op(dcache_maint_pkg::OP_COPYBACK, 32'hFFFF_FFFE, BLK_A, 7'h00);
    do_op(dcache_maint_pkg::OP_INVALIDATE, 32'h0000_0000, BLK_C, 7'h00);
    @(posedge clock_i);
    slow <= 1'b1;
    pend <= 1'b1;
    @(posedge clock_i);
    pend <= 1'b0;
    do_op(dcache_maint_pkg::OP_COPYBACK, 32'h0000_0003, BLK_A + 256, 7'h40);
    slow <= 1'b0;
    do_op(dcache_maint_pkg::OP_COPYBACK, 32'h0000_0001, BLK_A, 7'h00);
    do_op(dcache_maint_pkg::OP_COPYBACK, 32'h0000_0001, BLK_B, 7'h00);
    do_op(dcache_maint_pkg::OP_COPYBACK, 32'h0000_0001, 32'h0000_7000, 7'h00);
    nc_base_i <= 32'h0000_3000;
    nc_limit_i <= 32'h0000_4000;
    do_op(dcache_maint_pkg::OP_COPYBACK, 32'h0000_0001, BLK_C, 7'h00);
    do_op(dcache_maint_pkg::OP_INVALIDATE, 32'h0000_0001, BLK_C, 7'h00);
    nc_base_i <= 32'h0000_0000;
    nc_limit_i <= 32'h0000_0000;
    @(posedge clock_i);
    pend <= 1'b1;
    @(posedge clock_i);
    pend <= 1'b0;
    do_op(dcache_maint_pkg::OP_INVALIDATE, 32'h0000_0001, BLK_C - 252, 7'h3F);
    do_op(dcache_maint_pkg::OP_INVALIDATE, 32'h0000_0005, BLK_B + 8, 7'h7F);
    do_op(dcache_maint_pkg::OP_INVALIDATE, 32'h0000_0001, 32'h0000_7000, 7'h00);
    chk("drain_first", 0, mem.early);
    finish_test();
  end
endmodule

`default_nettype wire
